// file: src/remote_annunciator_option_logic.sv
// Functional notes
// - custom mode selects queue type 2 or 3
// - lcd source queues panel events with panel stamp
// - lcd source clear drops panel event messages
// - led source queues led alarms, local time
// - non-lcd modes force lcd off, led on at config write
// - each buzzer is OR of two enabled generators; fault buzzer also ORs link lost and system fault
// - local alarm generator sounds mapped zone alarms
// - local fault generator sounds mapped zone faults
// - remote generators follow panel buzzers
// - defaults enable local, disable remote generators
// - local system faults always sound fault buzzer
// - alarm and system fault lamps OR local and remote
// - remote only feeds alarm and system fault
// - auto ack marks events acked locally only
// - all zones isolated raises system fault
// - forward mode forces follow on, local off
// - forward key press sends inverse isolate command
// - forward mode updates only from returned state
// - forward mode flashes lamp 1 Hz when isolated
// - no alarm relays rejects enabling local
// - follow isolates bells on panel isolate
// - follow plus local ORs; key toggles local
`timescale 1ns/1ps
`include "annunciator_cfg.svh"

module remote_annunciator_option_logic (
    input wire logic sys_clk,
    input wire logic rst,
    // configuration
    input wire annunciator_pkg::op_mode_t op_mode,
    input wire logic cfg_queue_type3,
    input wire logic cfg_lcd_msg,
    input wire logic cfg_led_msg,
    input wire annunciator_pkg::buzzer_gen_t cfg_buzzer,
    input wire annunciator_pkg::lamp_gen_t cfg_lamps,
    input wire logic cfg_auto_ack,
    input wire logic cfg_all_iso_fault,
    input wire annunciator_pkg::bells_opt_t cfg_bells,
    input wire logic cfg_write,
    input wire logic has_alarm_relays,
    // panel status
    input wire logic panel_event_valid,
    input wire annunciator_pkg::panel_event_t panel_event,
    input wire logic led_alarm_valid,
    input wire logic [7:0] led_alarm_zone,
    input wire logic [31:0] local_time,
    input wire logic mapped_alarm,
    input wire logic mapped_fault,
    input wire logic panel_alarm_buzzer,
    input wire logic panel_fault_buzzer,
    input wire logic panel_alarm_lamp,
    input wire logic panel_sysfault_lamp,
    input wire logic panel_bells_isolated,
    input wire logic link_lost,
    input wire logic local_sys_fault,
    input wire logic [4:0] local_lamp_status,
    input wire logic all_zones_isolated,
    input wire logic bell_silence_key,
    // outputs
    output annunciator_pkg::queue_event_t queue_event,
    output logic queue_event_valid,
    output logic alarm_buzzer,
    output logic fault_buzzer,
    output logic [4:0] common_lamps,
    output logic system_fault,
    output logic bells_isolated,
    output logic bells_isolate_lamp,
    output logic bells_cmd_valid,
    output logic bells_cmd_isolate,
    output logic cfg_rejected,
    output annunciator_pkg::bells_opt_t bells_opt_eff
);
    import annunciator_pkg::*;

    localparam int FLASH_HALF = `FLASH_HALF_CYCLES;

    logic queue_type3_reg;
    logic lcd_msg_reg;
    logic led_msg_reg;
    buzzer_gen_t buz_reg;
    lamp_gen_t lamp_reg;
    logic auto_ack_reg;
    logic all_iso_reg;
    bells_opt_t bells_reg;
    bells_opt_t bells_next;
    logic local_iso_reg;
    logic key_prev_reg;
    logic key_press;
    logic [27:0] flash_cnt_reg;
    logic flash_reg;
    logic nonlcd;
    logic sys_fault_next;
    logic lamp_alarm;
    logic lamp_isolated;
    logic lamp_fault;
    logic lamp_charger;
    logic lamp_sysfault;

    assign nonlcd = (op_mode == MODE_NONLCD) || (op_mode == MODE_NONLCD_MIMIC);
    assign key_press = bell_silence_key && !key_prev_reg;

    // bells options after forcing; a local request without relays is refused
    always_comb begin
        bells_next = cfg_bells;
        if (cfg_bells.passon) begin
            bells_next.follow = 1'b1;
            bells_next.local_en = 1'b0;
        end else if (cfg_bells.local_en && !has_alarm_relays) begin
            bells_next.local_en = 1'b0;
        end
    end

    // configuration store, loaded with defaults on reset
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            queue_type3_reg <= `DEF_QUEUE_TYPE3;
            lcd_msg_reg <= `DEF_LCD_MSG;
            led_msg_reg <= `DEF_LED_MSG;
            buz_reg <= {`DEF_BUZ_LOCAL_ALARM, `DEF_BUZ_LOCAL_FAULT,
                `DEF_BUZ_REMOTE_ALARM, `DEF_BUZ_REMOTE_FAULT};
            lamp_reg <= {{5{`DEF_LED_LOCAL}}, {5{`DEF_LED_REMOTE}}};
            auto_ack_reg <= `DEF_AUTO_ACK;
            all_iso_reg <= `DEF_ALL_ISO_FAULT;
            bells_reg <= 3'b000;
            cfg_rejected <= 1'b0;
        end else if (cfg_write) begin
            // type choice only honoured in custom mode
            queue_type3_reg <= (op_mode == MODE_CUSTOM) ? cfg_queue_type3
                : 1'b0;
            lcd_msg_reg <= nonlcd ? 1'b0 : cfg_lcd_msg;
            led_msg_reg <= nonlcd ? 1'b1 : cfg_led_msg;
            buz_reg <= cfg_buzzer;
            lamp_reg <= cfg_lamps;
            auto_ack_reg <= cfg_auto_ack;
            all_iso_reg <= cfg_all_iso_fault;
            bells_reg <= bells_next;
            cfg_rejected <= !cfg_bells.passon && cfg_bells.local_en
                && !has_alarm_relays;
        end
    end

    assign bells_opt_eff = bells_reg;

    // queue event creation; panel messages win if both arrive together
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            queue_event <= '0;
            queue_event_valid <= 1'b0;
        end else begin
            queue_event_valid <= 1'b0;
            if (panel_event_valid && lcd_msg_reg) begin
                queue_event.zone <= panel_event.zone;
                queue_event.alarm_type <= panel_event.alarm_type;
                queue_event.time_date <= panel_event.time_date;
                queue_event.text_alarm <= 1'b0;
                queue_event.acked <= auto_ack_reg;
                queue_event.type3 <= queue_type3_reg;
                queue_event_valid <= 1'b1;
            end else if (led_alarm_valid && led_msg_reg) begin
                queue_event.zone <= led_alarm_zone;
                queue_event.alarm_type <= 8'h00;
                queue_event.time_date <= local_time;
                queue_event.text_alarm <= 1'b1;
                queue_event.acked <= auto_ack_reg;
                queue_event.type3 <= queue_type3_reg;
                queue_event_valid <= 1'b1;
            end
        end
    end

    // buzzers; system faults bypass the generator enables
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            alarm_buzzer <= 1'b0;
            fault_buzzer <= 1'b0;
        end else begin
            alarm_buzzer <= (buz_reg.local_alarm && mapped_alarm)
                || (buz_reg.remote_alarm && panel_alarm_buzzer);
            fault_buzzer <= (buz_reg.local_fault && mapped_fault)
                || (buz_reg.remote_fault && panel_fault_buzzer)
                || link_lost || sys_fault_next;
        end
    end

    // system fault includes the all-isolated safeguard
    assign sys_fault_next = local_sys_fault
        || (all_iso_reg && all_zones_isolated);

    // system fault output, registered alongside the lamps
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            system_fault <= 1'b0;
        end else begin
            system_fault <= sys_fault_next;
        end
    end

    // alarm lamp can also follow the panel alarm status
    lamp_or_cell #(
        .HAS_REMOTE(1'b1)
    ) alarm_lamp (
        .sys_clk(sys_clk),
        .rst(rst),
        .local_en(lamp_reg.local_en[`LAMP_ALARM]),
        .local_stat(local_lamp_status[`LAMP_ALARM]),
        .remote_en(lamp_reg.remote_en[`LAMP_ALARM]),
        .remote_stat(panel_alarm_lamp),
        .lamp(lamp_alarm)
    );

    // panel sends no isolated status, so no remote path is built
    lamp_or_cell #(
        .HAS_REMOTE(1'b0)
    ) isolated_lamp (
        .sys_clk(sys_clk),
        .rst(rst),
        .local_en(lamp_reg.local_en[`LAMP_ISOLATED]),
        .local_stat(local_lamp_status[`LAMP_ISOLATED]),
        .remote_en(lamp_reg.remote_en[`LAMP_ISOLATED]),
        .remote_stat(1'b0),
        .lamp(lamp_isolated)
    );

    // panel sends no fault lamp status either
    lamp_or_cell #(
        .HAS_REMOTE(1'b0)
    ) fault_lamp (
        .sys_clk(sys_clk),
        .rst(rst),
        .local_en(lamp_reg.local_en[`LAMP_FAULT]),
        .local_stat(local_lamp_status[`LAMP_FAULT]),
        .remote_en(lamp_reg.remote_en[`LAMP_FAULT]),
        .remote_stat(1'b0),
        .lamp(lamp_fault)
    );

    // charger and battery lamp is local only
    lamp_or_cell #(
        .HAS_REMOTE(1'b0)
    ) charger_lamp (
        .sys_clk(sys_clk),
        .rst(rst),
        .local_en(lamp_reg.local_en[`LAMP_CHARGER]),
        .local_stat(local_lamp_status[`LAMP_CHARGER]),
        .remote_en(lamp_reg.remote_en[`LAMP_CHARGER]),
        .remote_stat(1'b0),
        .lamp(lamp_charger)
    );

    // system fault lamp: local term includes the all-isolated fault
    lamp_or_cell #(
        .HAS_REMOTE(1'b1)
    ) sysfault_lamp (
        .sys_clk(sys_clk),
        .rst(rst),
        .local_en(lamp_reg.local_en[`LAMP_SYSFAULT]),
        .local_stat(sys_fault_next),
        .remote_en(lamp_reg.remote_en[`LAMP_SYSFAULT]),
        .remote_stat(panel_sysfault_lamp),
        .lamp(lamp_sysfault)
    );

    // lamp vector in field order, bit 0 is the alarm lamp
    assign common_lamps = {lamp_sysfault, lamp_charger, lamp_fault,
        lamp_isolated, lamp_alarm};

    // local bells isolate state and key edge
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            local_iso_reg <= 1'b0;
            key_prev_reg <= 1'b0;
        end else begin
            key_prev_reg <= bell_silence_key;
            if (key_press && bells_reg.local_en && !bells_reg.passon) begin
                local_iso_reg <= !local_iso_reg;
            end
        end
    end

    // forward mode: key sends the inverse of the panel state
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bells_cmd_valid <= 1'b0;
            bells_cmd_isolate <= 1'b0;
        end else begin
            bells_cmd_valid <= key_press && bells_reg.passon;
            if (key_press && bells_reg.passon) begin
                bells_cmd_isolate <= !panel_bells_isolated;
            end
        end
    end

    // 1 Hz flash divider; the counter wrap toggles the flash phase
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            flash_cnt_reg <= '0;
            flash_reg <= 1'b0;
        end else if (flash_cnt_reg == 28'(FLASH_HALF - 1)) begin
            flash_cnt_reg <= '0;
            flash_reg <= !flash_reg;
        end else begin
            flash_cnt_reg <= flash_cnt_reg + 28'd1;
        end
    end

    // bells relay state and lamp; forward mode uses panel state only
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bells_isolated <= 1'b0;
            bells_isolate_lamp <= 1'b0;
        end else begin
            bells_isolated <= (bells_reg.follow && panel_bells_isolated)
                || (bells_reg.local_en && local_iso_reg);
            if (bells_reg.passon) begin
                bells_isolate_lamp <= panel_bells_isolated && flash_reg;
            end else begin
                bells_isolate_lamp <= (bells_reg.follow && panel_bells_isolated)
                    || (bells_reg.local_en && local_iso_reg);
            end
        end
    end

endmodule : remote_annunciator_option_logic

// one common lamp: OR of an enabled local and an enabled remote generator;
// lamps with no panel status drop the remote path so it cannot light them
module lamp_or_cell #(
    parameter bit HAS_REMOTE = 1'b1
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic local_en,
    input wire logic local_stat,
    input wire logic remote_en,
    input wire logic remote_stat,
    output logic lamp
);
    logic remote_term;

    // remote term tied off where the panel sends nothing
    assign remote_term = HAS_REMOTE ? (remote_en && remote_stat) : 1'b0;

    // registered so the lamp never shows a combinational glitch
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            lamp <= 1'b0;
        end else begin
            lamp <= (local_en && local_stat) || remote_term;
        end
    end

endmodule : lamp_or_cell

// file: src/annunciator_cfg.svh
`ifndef ANNUNCIATOR_CFG_SVH
`define ANNUNCIATOR_CFG_SVH

// system clock rate and lamp flash timing
`define CLK_HZ 250_000_000
`define FLASH_HZ 1
// half period of the 1 Hz flash, in clock cycles
`define FLASH_HALF_CYCLES (`CLK_HZ / (2 * `FLASH_HZ))

// configuration defaults applied on reset
`define DEF_BUZ_LOCAL_ALARM 1'b1
`define DEF_BUZ_LOCAL_FAULT 1'b1
`define DEF_BUZ_REMOTE_ALARM 1'b0
`define DEF_BUZ_REMOTE_FAULT 1'b0
`define DEF_LED_LOCAL 1'b1
`define DEF_LED_REMOTE 1'b0
`define DEF_AUTO_ACK 1'b0
`define DEF_ALL_ISO_FAULT 1'b1
`define DEF_LCD_MSG 1'b1
`define DEF_LED_MSG 1'b0
`define DEF_QUEUE_TYPE3 1'b0

// field positions in the lamp vector
`define LAMP_ALARM 0
`define LAMP_ISOLATED 1
`define LAMP_FAULT 2
`define LAMP_CHARGER 3
`define LAMP_SYSFAULT 4

`endif

// file: src/annunciator_pkg.sv
package annunciator_pkg;

    typedef enum logic [1:0] {
        MODE_CUSTOM = 2'b00,
        MODE_LCD = 2'b01,
        MODE_NONLCD = 2'b11,
        MODE_NONLCD_MIMIC = 2'b10
    } op_mode_t;

    typedef struct packed {
        logic local_alarm;
        logic local_fault;
        logic remote_alarm;
        logic remote_fault;
    } buzzer_gen_t;

    typedef struct packed {
        logic [4:0] local_en;
        logic [4:0] remote_en;
    } lamp_gen_t;

    typedef struct packed {
        logic passon;
        logic follow;
        logic local_en;
    } bells_opt_t;

    typedef struct packed {
        logic [7:0] zone;
        logic [7:0] alarm_type;
        logic [31:0] time_date;
    } panel_event_t;

    typedef struct packed {
        logic [7:0] zone;
        logic [7:0] alarm_type;
        logic [31:0] time_date;
        logic text_alarm;
        logic acked;
        logic type3;
    } queue_event_t;

endpackage : annunciator_pkg

// file: dv/remote_annunciator_option_logic_chk.sv
`timescale 1ns/1ps
module remote_annunciator_option_logic_chk (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic bell_silence_key,
    input wire logic panel_bells_isolated,
    input wire annunciator_pkg::bells_opt_t bells_opt_eff,
    input wire logic cfg_write,
    input wire logic bells_cmd_valid,
    input wire logic bells_cmd_isolate,
    input wire logic bells_isolated,
    input wire logic bells_isolate_lamp,
    input wire logic cfg_rejected,
    input wire logic link_lost,
    input wire logic local_sys_fault,
    input wire logic fault_buzzer,
    input wire logic mapped_alarm,
    input wire logic panel_alarm_buzzer,
    input wire logic alarm_buzzer,
    input wire logic [4:0] local_lamp_status,
    input wire logic [4:0] common_lamps,
    input wire logic queue_event_valid,
    input wire logic panel_event_valid,
    input wire logic led_alarm_valid
);
    import annunciator_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // each check ties an output to its cause; system_fault and queue_event go unchecked
    a_sys_fault_buzz: assert property (link_lost || local_sys_fault |=>
        fault_buzzer) else $error("fault buzzer silent on system fault");
    a_key_cmd_inverse: assert property ($rose(bell_silence_key) &&
        bells_opt_eff.passon |=> bells_cmd_valid &&
        bells_cmd_isolate == !$past(panel_bells_isolated))
        else $error("bad isolate command");
    a_passon_forces: assert property (bells_opt_eff.passon |->
        bells_opt_eff.follow && !bells_opt_eff.local_en)
        else $error("passon options not forced");
    a_reject_local: assert property (cfg_rejected |->
        !bells_opt_eff.local_en) else $error("local kept after reject");
    a_follow_panel: assert property (!cfg_write && bells_opt_eff.follow &&
        panel_bells_isolated |=> bells_isolated)
        else $error("bells not isolated with panel");
    a_alarm_quiet: assert property (!mapped_alarm && !panel_alarm_buzzer
        |=> !alarm_buzzer) else $error("alarm buzzer without cause");
    a_lamps_local_only: assert property (local_lamp_status[3:1] == 3'h0
        |=> common_lamps[3:1] == 3'h0) else $error("lamp lit by remote");
    a_queue_cause: assert property (queue_event_valid |->
        $past(panel_event_valid) || $past(led_alarm_valid))
        else $error("queue event without input");
    a_lamp_dark: assert property ((bells_opt_eff.passon &&
        !panel_bells_isolated)[*3] |-> !bells_isolate_lamp)
        else $error("bells lamp lit while not isolated");
    c_queue: cover property (queue_event_valid);
    c_cmd: cover property (bells_cmd_valid);
    c_iso: cover property ($rose(bells_isolated));
endmodule : remote_annunciator_option_logic_chk

bind remote_annunciator_option_logic remote_annunciator_option_logic_chk
    props (.*);

// file: dv/panel_model.sv
`timescale 1ns/1ps
// master panel bells isolate state; answers a command lat+1 cycles after taking it
module panel_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire logic cmd_isolate,
    input wire logic set_en,
    input wire logic set_val,
    input wire logic [3:0] lat,
    output logic bells_iso
);
    logic pend_reg;
    logic val_reg;
    logic [3:0] cnt_reg;
    // own key at the panel wins over a remote command arriving in the same cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bells_iso <= 1'h0;
            pend_reg <= 1'h0;
        end else if (set_en) begin
            bells_iso <= set_val;
        end else if (cmd_valid) begin
            pend_reg <= 1'h1;
            val_reg <= cmd_isolate;
            cnt_reg <= lat;
        end else if (pend_reg) begin
            cnt_reg <= cnt_reg - 4'h1;
            if (cnt_reg == 4'h0) begin
                bells_iso <= val_reg;
                pend_reg <= 1'h0;
            end
        end
    end
endmodule : panel_model

// file: dv/remote_annunciator_option_logic_test.sv
`timescale 1ns/1ps
module remote_annunciator_option_logic_test;
    import annunciator_pkg::*;
    op_mode_t op_mode;
    buzzer_gen_t cfg_buzzer;
    lamp_gen_t cfg_lamps;
    bells_opt_t cfg_bells, bells_opt_eff;
    panel_event_t panel_event;
    queue_event_t queue_event;
    logic sys_clk, rst, cfg_queue_type3, cfg_lcd_msg, cfg_led_msg;
    logic cfg_auto_ack, cfg_all_iso_fault, cfg_write, has_alarm_relays;
    logic panel_event_valid, led_alarm_valid, mapped_alarm, mapped_fault;
    logic panel_alarm_buzzer, panel_fault_buzzer, panel_alarm_lamp;
    logic panel_sysfault_lamp, panel_bells_isolated, link_lost;
    logic local_sys_fault, all_zones_isolated, bell_silence_key;
    logic queue_event_valid, alarm_buzzer, fault_buzzer, system_fault;
    logic bells_isolated, bells_isolate_lamp, bells_cmd_valid;
    logic bells_cmd_isolate, cfg_rejected, set_en, set_val;
    logic [7:0] led_alarm_zone;
    logic [31:0] local_time;
    logic [4:0] local_lamp_status, common_lamps;
    logic [3:0] lat;
    int mismatches = 0, cmp_count = 0, cyc = 0;

    remote_annunciator_option_logic uut (.*);
    panel_model partner (.sys_clk, .rst, .cmd_valid(bells_cmd_valid),
        .cmd_isolate(bells_cmd_isolate), .set_en, .set_val, .lat,
        .bells_iso(panel_bells_isolated));

    // free running clock
    initial begin
        sys_clk = 0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic tick(int n = 1);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    task automatic chk(string what, logic [63:0] seen, logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wcfg();
        cfg_write = 1;
        tick();
        cfg_write = 0;
    endtask : wcfg
    task automatic press();
        bell_silence_key = 1;
        tick();
        bell_silence_key = 0;
    endtask : press
    task automatic summarize();
        $display("checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : summarize
    function automatic logic [1:0] exp_buz();
        return {cfg_buzzer.local_alarm & mapped_alarm |
            cfg_buzzer.remote_alarm & panel_alarm_buzzer,
            cfg_buzzer.local_fault & mapped_fault |
            cfg_buzzer.remote_fault & panel_fault_buzzer |
            link_lost | local_sys_fault};
    endfunction : exp_buz
    function automatic logic [3:0] exp_lamps();
        return cfg_lamps.local_en[3:0] & local_lamp_status[3:0] |
            {3'h0, cfg_lamps.remote_en[0] & panel_alarm_lamp};
    endfunction : exp_lamps

    // a hang is cut short well past the expected run length
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 4000) begin
            mismatches++;
            summarize();
        end
    end

    initial begin
        {cfg_queue_type3, cfg_led_msg, cfg_auto_ack, cfg_bells, cfg_write,
            panel_event_valid, panel_event, led_alarm_valid, led_alarm_zone,
            local_time, mapped_alarm, mapped_fault, panel_alarm_buzzer,
            panel_fault_buzzer, panel_alarm_lamp, panel_sysfault_lamp,
            link_lost, local_sys_fault, local_lamp_status, all_zones_isolated,
            bell_silence_key, set_en, set_val, lat} = '0;
        {rst, cfg_lcd_msg, cfg_all_iso_fault, has_alarm_relays} = 4'hf;
        op_mode = MODE_CUSTOM;
        cfg_buzzer = 4'hc;
        cfg_lamps = 10'h3e0;
        void'($urandom(32'h90dc_f5f1));
        tick(8);
        rst = 0;
        // first two rounds run on reset defaults, then random generators
        for (int i = 0; i < 24; i++) begin
            if (i > 1) begin
                {cfg_buzzer, cfg_lamps} = 14'($urandom);
                wcfg();
            end
            {mapped_alarm, mapped_fault, panel_alarm_buzzer, panel_fault_buzzer,
                panel_alarm_lamp, panel_sysfault_lamp, link_lost,
                local_sys_fault, local_lamp_status} = 13'($urandom);
            if (i < 2) begin
                {mapped_alarm, mapped_fault, link_lost} = {i[0], i[0], 1'h0};
                {panel_alarm_buzzer, panel_fault_buzzer} = {2{!i[0]}};
                local_sys_fault = 0;
            end
            tick();
            chk("buzzers", {alarm_buzzer, fault_buzzer}, exp_buz());
            chk("lamps", common_lamps[3:0], exp_lamps());
            chk("sysfault", {system_fault, common_lamps[4]}, {local_sys_fault, cfg_lamps.local_en[4] & local_sys_fault | cfg_lamps.remote_en[4] & panel_sysfault_lamp});
        end
        {link_lost, local_sys_fault, mapped_fault, panel_fault_buzzer} = '0;
        all_zones_isolated = 1;
        tick();
        chk("all_iso", {system_fault, fault_buzzer}, 2'h3);
        cfg_all_iso_fault = 0;
        wcfg();
        tick();
        chk("all_iso_off", system_fault, 1'h0);
        all_zones_isolated = 0;
        // queue flavours in custom and lcd modes, then both non-lcd modes
        for (int i = 0; i < 6; i++) begin
            op_mode = i == 1 ? MODE_LCD : i < 4 ? MODE_CUSTOM
                : i == 4 ? MODE_NONLCD : MODE_NONLCD_MIMIC;
            {cfg_auto_ack, cfg_queue_type3} = 2'(i);
            cfg_lcd_msg = i != 3;
            wcfg();
            panel_event = 48'({$urandom(), $urandom()});
            panel_event_valid = 1;
            tick();
            panel_event_valid = 0;
            if (i < 3) chk("queue", {queue_event_valid, queue_event}, {1'h1, panel_event, 1'h0, i[1], i[0] && i != 1});
            else chk("queue_drop", queue_event_valid, 1'h0);
            led_alarm_zone = 8'($urandom);
            local_time = $urandom;
            led_alarm_valid = 1;
            tick();
            led_alarm_valid = 0;
            if (i > 3) chk("led_queue", {queue_event_valid, queue_event.zone, queue_event.time_date, queue_event.text_alarm, queue_event.type3}, {1'h1, led_alarm_zone, local_time, 2'h2});
            else chk("led_drop", queue_event_valid, 1'h0);
        end
        op_mode = MODE_CUSTOM;
        has_alarm_relays = 0;
        cfg_bells = 3'h5;
        wcfg();
        chk("passon", {bells_opt_eff, cfg_rejected}, 4'hc);
        // panel answers promptly, then slowly
        for (int i = 0; i < 2; i++) begin
            lat = i ? 4'h9 : 4'h0;
            press();
            chk("cmd", {bells_cmd_valid, bells_cmd_isolate, bells_isolated}, {1'h1, !i[0], i[0]});
            repeat (20) if (bells_isolated !== !i[0]) tick();
            chk("returned", bells_isolated, !i[0]);
        end
        tick(3);
        chk("lamp_off", bells_isolate_lamp, 1'h0);
        cfg_bells = 3'h1;
        wcfg();
        chk("reject", {bells_opt_eff, cfg_rejected}, 4'h1);
        has_alarm_relays = 1;
        cfg_bells = 3'h2;
        wcfg();
        {set_en, set_val} = 2'h3;
        tick();
        set_en = 0;
        tick();
        press();
        chk("follow", {bells_isolated, bells_cmd_valid}, 2'h2);
        {set_en, set_val} = 2'h2;
        tick();
        set_en = 0;
        cfg_bells = 3'h3;
        wcfg();
        for (int i = 0; i < 3; i++) begin
            press();
            tick();
            chk("local_toggle", {bells_isolated, bells_isolate_lamp}, {2{!i[0]}});
        end
        rst = 1;
        tick(2);
        rst = 0;
        wcfg();
        tick();
        chk("reset_local", bells_isolated, 1'h0);
        summarize();
    end
endmodule : remote_annunciator_option_logic_test
